//--- hw/pbhs_pkg.sv
package pbhs_pkg;
  // Clock and time figures.
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_NS        = 40;
  localparam int RST_PULSE_NS  = 200;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Histogram geometry.
  localparam int       BIN_W     = 13;
  localparam int       NBINS_MAX = 8192;
  localparam int       GAIN_FRAC = 8;
  localparam [12:0]    BIN_LAST  = 13'h1FFF;
  localparam [13:0]    NBINS_MIN = 14'h0200;
  localparam [13:0]    NBINS_TOP = 14'h2000;
  localparam [15:0]    OFF_MAX   = 16'h0100;
  localparam [15:0]    OFF_MIN   = 16'hFF00;
  // Register byte addresses.
  localparam [7:0] A_CTRL  = 8'h00;
  localparam [7:0] A_THR   = 8'h04;
  localparam [7:0] A_DLY   = 8'h08;
  localparam [7:0] A_HCFG  = 8'h0C;
  localparam [7:0] A_GAIN  = 8'h10;
  localparam [7:0] A_OFF   = 8'h14;
  localparam [7:0] A_IDX   = 8'h18;
  localparam [7:0] A_BIN   = 8'h1C;
  localparam [7:0] A_REAL  = 8'h20;
  localparam [7:0] A_LIVE  = 8'h24;
  localparam [7:0] A_INCNT = 8'h28;
  localparam [7:0] A_OUTCN = 8'h2C;
  localparam [7:0] A_ICR   = 8'h30;
  localparam [7:0] A_OCR   = 8'h34;
  // Control register bit positions, and the histogram configuration byte-width field.
  localparam int C_START = 0;
  localparam int C_STOP  = 1;
  localparam int C_DYNEN = 2;
  localparam int C_SNAP  = 3;
  localparam int C_RUN   = 4;
  localparam int C_BUSY  = 5;
  localparam int HB_POS  = 16;
  // Values after reset, and the last divider iteration.
  localparam [15:0] THR_RST   = 16'h6000;
  localparam [15:0] DLY_RST   = 16'h0040;
  localparam [15:0] GAIN_RST  = 16'h0100;
  localparam [1:0]  BYTES_RST = 2'h3;
  localparam [5:0]  DIV_LAST  = 6'h3F;

  typedef enum logic [1:0] {DR_IDLE, DR_WAIT, DR_PULSE, DR_HOLD} pbhs_dr_type;
  typedef enum logic [1:0] {DV_IDLE, DV_ICR, DV_OCR} pbhs_dv_type;
endpackage

//--- hw/pbhs_map_if.sv
`timescale 1ns/1ps
interface pbhs_map_if;
  logic        [15:0] energy;
  logic               e_valid;
  logic        [15:0] gain;
  logic signed [9:0]  offset;
  logic               bin_valid;
  logic        [12:0] bin;
  modport src (output energy, e_valid, gain, offset, input bin_valid, bin);
  modport map (input energy, e_valid, gain, offset, output bin_valid, bin);
endinterface

//--- hw/pbhs_map.sv
`timescale 1ns/1ps
module pbhs_map
  import pbhs_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // Energy in, bin out
  pbhs_map_if.map   m
);
  logic        [31:0] prod;
  logic signed [25:0] pos;

  always_comb begin
    prod = 32'(m.energy) * 32'(m.gain);
    pos  = signed'({2'b00, prod[31:GAIN_FRAC]}) + 26'(m.offset);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m.bin_valid <= 1'b0;
      m.bin       <= 13'h0000;
    end else if (ce_i) begin
      m.bin_valid <= m.e_valid;
      if (m.e_valid) begin
        if (pos < 26'sh0)
          m.bin <= 13'h0000;
        else if (pos > signed'({13'h0000, BIN_LAST}))
          m.bin <= BIN_LAST;
        else
          m.bin <= pos[12:0];
      end
    end
  end

  low_clamp_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && m.e_valid && pos < 0 |=> m.bin_valid && m.bin == 13'h0000)
    else $error("below range not sorted to bin 0");
  high_clamp_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && m.e_valid && pos > 8191 |=> m.bin == BIN_LAST)
    else $error("above range not sorted to last bin");
  gain_offset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && m.e_valid && pos >= 0 && pos <= 8191
    |=> m.bin == 13'(($past(32'(m.energy) * 32'(m.gain)) >> 8) + 32'($past(m.offset))))
    else $error("gain and offset mapping wrong");
endmodule

//--- hw/pbhs_top.sv
// Behaviour
// - over threshold, wait peak+gap, pulse reset.
// - enable bit; disabled means no early reset.
// - dynamic reset threshold is programmable.
// - count each valid energy into one bin.
// - bin count configurable 512 to 8192.
// - bin width one, two or three bytes.
// - bins wrap to zero, never saturate.
// - multiply energy by digital gain.
// - add signed bin offset, -256..+256.
// - below range goes to bin 0.
// - above range goes to bin 8191.
// - real time counts from run start.
// - live time only when detection active.
// - count every fast filter event.
// - count every evaluated energy event.
// - input rate is input counts over live.
// - output rate is output counts over real.
// - statistics captured at one instant.
// - live time stops when converter overranges.
`timescale 1ns/1ps
module pbhs_top
  import pbhs_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  // Register port
  input  wire logic        [7:0]  addr_i,
  input  wire logic        [31:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output      logic        [31:0] rdata_o,
  // Upstream pulse logic
  input  wire logic signed [15:0] ramp_i,
  input  wire logic               fast_trig_i,
  input  wire logic               fast_event_i,
  input  wire logic               reset_det_i,
  input  wire logic               adc_oor_i,
  input  wire logic        [15:0] energy_i,
  input  wire logic               energy_valid_i,
  // Preamplifier
  output      logic               dyn_reset_o
);
  logic               run_act_r;
  logic               dyn_en_r;
  logic signed [15:0] dyn_thr_r;
  logic        [15:0] dyn_dly_r;
  logic        [13:0] nbins_r;
  logic        [1:0]  bytes_r;
  logic        [15:0] gain_r;
  logic signed [9:0]  off_r;
  logic        [12:0] idx_r;
  logic        [31:0] real_r, live_r, incnt_r, outcnt_r;
  logic        [31:0] s_real_r, s_live_r, s_in_r, s_out_r, icr_r, ocr_r;
  logic        [23:0] bins_r [NBINS_MAX];
  pbhs_dr_type        dr_state_r;
  logic        [15:0] dr_cnt_r;
  pbhs_dv_type        dv_state_r;
  logic        [63:0] dv_num_r;
  logic        [32:0] dv_rem_r;
  logic        [31:0] dv_den_r;
  logic        [5:0]  dv_it_r;
  logic        [32:0] rem_sh, rem_nxt;
  logic               dv_ge;
  logic        [63:0] num_nxt;
  logic               ctl_wr, start, stop, snap;
  logic signed [15:0] off_w;
  logic        [13:0] nb_w;

  pbhs_map_if hb ();

  function automatic logic [23:0] bin_mask(input logic [1:0] b);
    return (b == 2'h1) ? 24'h0000FF : (b == 2'h2) ? 24'h00FFFF : 24'hFFFFFF;
  endfunction

  function automatic logic [63:0] scale_cps(input logic [31:0] c);
    return 64'(c) * 64'(CLK_HZ);
  endfunction

  function automatic logic [31:0] sat32(input logic [63:0] q, input logic [31:0] d);
    if (d == 32'h0)
      return 32'h0;
    return (q[63:32] != 32'h0) ? 32'hFFFFFFFF : q[31:0];
  endfunction

  assign ctl_wr = ce_i && wr_i && (addr_i == A_CTRL);
  assign start  = ctl_wr && wdata_i[C_START];
  assign stop   = ctl_wr && wdata_i[C_STOP];
  assign snap   = ctl_wr && wdata_i[C_SNAP] && (dv_state_r == DV_IDLE);
  assign off_w  = signed'(wdata_i[15:0]);
  assign nb_w   = wdata_i[13:0];

  assign hb.energy  = energy_i;
  assign hb.e_valid = energy_valid_i && run_act_r;
  assign hb.gain    = gain_r;
  assign hb.offset  = off_r;

  pbhs_map u_map (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .m      (hb.map)
  );

  // Configuration registers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dyn_en_r  <= 1'b0;
      dyn_thr_r <= THR_RST;
      dyn_dly_r <= DLY_RST;
      nbins_r   <= NBINS_TOP;
      bytes_r   <= BYTES_RST;
      gain_r    <= GAIN_RST;
      off_r     <= 10'h000;
      idx_r     <= 13'h0000;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        A_CTRL: dyn_en_r <= wdata_i[C_DYNEN];
        A_THR:  dyn_thr_r <= wdata_i[15:0];
        A_DLY:  dyn_dly_r <= wdata_i[15:0];
        A_HCFG: begin
          nbins_r <= (nb_w < NBINS_MIN) ? NBINS_MIN : (nb_w > NBINS_TOP) ? NBINS_TOP : nb_w;
          bytes_r <= (wdata_i[HB_POS+1:HB_POS] == 2'h0) ? 2'h1 : wdata_i[HB_POS+1:HB_POS];
        end
        A_GAIN: gain_r <= wdata_i[15:0];
        A_OFF:  off_r <= (off_w > signed'(OFF_MAX)) ? 10'h100 :
                         (off_w < signed'(OFF_MIN)) ? 10'h300 : off_w[9:0];
        A_IDX:  idx_r <= wdata_i[12:0];
        default: ;
      endcase
    end
  end

  // Run statistics.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_act_r <= 1'b0;
      real_r    <= 32'h0;
      live_r    <= 32'h0;
      incnt_r   <= 32'h0;
      outcnt_r  <= 32'h0;
    end else if (ce_i) begin
      if (start) begin
        run_act_r <= 1'b1;
        real_r    <= 32'h0;
        live_r    <= 32'h0;
        incnt_r   <= 32'h0;
        outcnt_r  <= 32'h0;
      end else if (run_act_r) begin
        run_act_r <= !stop;
        // real time in clock periods; wraps after about 171 s.
        real_r    <= real_r + 32'h1;
        // live time gated; also stopped on overrange.
        if (!fast_trig_i && !reset_det_i && !adc_oor_i)
          live_r <= live_r + 32'h1;
        if (fast_event_i)
          incnt_r <= incnt_r + 32'h1;
        if (energy_valid_i)
          outcnt_r <= outcnt_r + 32'h1;
      end
    end
  end

  // Histogram bins.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NBINS_MAX; i++)
        bins_r[i] <= 24'h0;
    end else if (ce_i) begin
      if (start) begin
        // bins cleared; a mapped value in flight is dropped.
        for (int i = 0; i < NBINS_MAX; i++)
          bins_r[i] <= 24'h0;
      end else if (hb.bin_valid) begin
        // one increment per valid energy; wraps at width.
        bins_r[hb.bin] <= (bins_r[hb.bin] + 24'h1) & bin_mask(bytes_r);
      end
    end
  end

  // Snapshot and shared rate divider; a snapshot is refused while busy.
  always_comb begin
    rem_sh  = {dv_rem_r[31:0], dv_num_r[63]};
    dv_ge   = rem_sh >= {1'b0, dv_den_r};
    rem_nxt = dv_ge ? rem_sh - {1'b0, dv_den_r} : rem_sh;
    num_nxt = {dv_num_r[62:0], dv_ge};
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dv_state_r <= DV_IDLE;
      dv_num_r   <= 64'h0;
      dv_rem_r   <= 33'h0;
      dv_den_r   <= 32'h0;
      dv_it_r    <= 6'h00;
      s_real_r   <= 32'h0;
      s_live_r   <= 32'h0;
      s_in_r     <= 32'h0;
      s_out_r    <= 32'h0;
      icr_r      <= 32'h0;
      ocr_r      <= 32'h0;
    end else if (ce_i) begin
      unique case (dv_state_r)
        DV_IDLE: if (snap) begin
          // all four captured on the same edge.
          s_real_r   <= real_r;
          s_live_r   <= live_r;
          s_in_r     <= incnt_r;
          s_out_r    <= outcnt_r;
          dv_num_r   <= scale_cps(incnt_r);
          dv_den_r   <= live_r;
          dv_rem_r   <= 33'h0;
          dv_it_r    <= 6'h00;
          dv_state_r <= DV_ICR;
        end
        DV_ICR: begin
          dv_num_r <= num_nxt;
          dv_rem_r <= rem_nxt;
          dv_it_r  <= dv_it_r + 6'h01;
          if (dv_it_r == DIV_LAST) begin
            icr_r      <= sat32(num_nxt, dv_den_r);
            dv_num_r   <= scale_cps(s_out_r);
            dv_den_r   <= s_real_r;
            dv_rem_r   <= 33'h0;
            dv_state_r <= DV_OCR;
          end
        end
        DV_OCR: begin
          dv_num_r <= num_nxt;
          dv_rem_r <= rem_nxt;
          dv_it_r  <= dv_it_r + 6'h01;
          if (dv_it_r == DIV_LAST) begin
            ocr_r      <= sat32(num_nxt, dv_den_r);
            dv_state_r <= DV_IDLE;
          end
        end
      endcase
    end
  end

  // Dynamic reset sequencer.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dr_state_r  <= DR_IDLE;
      dr_cnt_r    <= 16'h0;
      dyn_reset_o <= 1'b0;
    end else if (ce_i) begin
      unique case (dr_state_r)
        DR_IDLE: if (dyn_en_r && ramp_i > dyn_thr_r) begin
          // crossing arms the peak plus gap wait.
          dr_state_r <= DR_WAIT;
          dr_cnt_r   <= dyn_dly_r;
        end
        DR_WAIT: begin
          if (!dyn_en_r) begin
            dr_state_r <= DR_IDLE;
          end else if (dr_cnt_r == 16'h0) begin
            dr_state_r  <= DR_PULSE;
            dr_cnt_r    <= 16'(RST_PULSE_CYC - 1);
            dyn_reset_o <= 1'b1;
          end else begin
            dr_cnt_r <= dr_cnt_r - 16'h1;
          end
        end
        DR_PULSE: begin
          if (!dyn_en_r || dr_cnt_r == 16'h0) begin
            dr_state_r  <= dyn_en_r ? DR_HOLD : DR_IDLE;
            dyn_reset_o <= 1'b0;
          end else begin
            dr_cnt_r <= dr_cnt_r - 16'h1;
          end
        end
        DR_HOLD: if (ramp_i <= dyn_thr_r)
          dr_state_r <= DR_IDLE;
      endcase
    end
  end

  // Register read; data valid only in the cycle after the strobe.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0;
    end else if (ce_i) begin
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          A_CTRL:  rdata_o <= 32'({dv_state_r != DV_IDLE, run_act_r, 1'b0, dyn_en_r, 2'b00});
          A_THR:   rdata_o <= 32'(unsigned'(dyn_thr_r));
          A_DLY:   rdata_o <= 32'(dyn_dly_r);
          A_HCFG:  rdata_o <= {14'h0, bytes_r, 2'b00, nbins_r};
          A_GAIN:  rdata_o <= 32'(gain_r);
          A_OFF:   rdata_o <= 32'(unsigned'(off_r));
          A_IDX:   rdata_o <= 32'(idx_r);
          A_BIN:   rdata_o <= (14'(idx_r) < nbins_r) ? 32'(bins_r[idx_r] & bin_mask(bytes_r))
                                                     : 32'h0;
          A_REAL:  rdata_o <= s_real_r;
          A_LIVE:  rdata_o <= s_live_r;
          A_INCNT: rdata_o <= s_in_r;
          A_OUTCN: rdata_o <= s_out_r;
          A_ICR:   rdata_o <= icr_r;
          A_OCR:   rdata_o <= ocr_r;
          default: rdata_o <= 32'h0;
        endcase
      end
    end
  end

  // The edge on which the wait runs out and the pulse is launched.
  sequence arm_s;
    ce_i && dyn_en_r && dr_state_r == DR_WAIT && dr_cnt_r == 16'h0;
  endsequence

  // Five enabled edges carry the pulse through its full length.
  sequence en_s;
    (ce_i && dyn_en_r) [*5];
  endsequence

  dyn_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !dyn_en_r |=> !dyn_reset_o)
    else $error("early reset while disabled");
  dyn_arm_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && dr_state_r == DR_IDLE && dyn_en_r && ramp_i > dyn_thr_r |=> dr_state_r == DR_WAIT)
    else $error("threshold crossing not armed");
  dyn_delay_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(dyn_reset_o) |-> $past(dr_state_r) == DR_WAIT && $past(dr_cnt_r) == 16'h0)
    else $error("reset before delay expired");
  dyn_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    arm_s |=> dyn_reset_o)
    else $error("reset request not raised after delay");
  pulse_len_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    arm_s ##1 en_s |-> dyn_reset_o ##1 !dyn_reset_o)
    else $error("reset request length wrong");
  live_stop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && run_act_r && !start && adc_oor_i |=> live_r == $past(live_r))
    else $error("live time ran during overrange");
  in_cnt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && run_act_r && !start && fast_event_i |=> incnt_r == $past(incnt_r) + 32'h1)
    else $error("input event not counted");
  run_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start |=> real_r == 32'h0 && outcnt_r == 32'h0 && bins_r[0] == 24'h0)
    else $error("run start did not clear");
  snap_same_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    snap |=> s_real_r == $past(real_r) && s_in_r == $past(incnt_r))
    else $error("snapshot not taken at one instant");
  bin_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !start && hb.bin_valid && bytes_r == 2'h2 && bins_r[hb.bin] == 24'h00FFFF
    |=> bins_r[$past(hb.bin)] == 24'h0)
    else $error("bin did not wrap to zero");
endmodule

//--- tb/pbhs_partner.sv
`timescale 1ns/1ps
module pbhs_partner
  import pbhs_pkg::*;
(
  // Clock and reset request from the block
  input  wire logic               clk_i,
  input  wire logic               dyn_reset_i,
  // Upstream pulse logic and preamplifier
  output      logic signed [15:0] ramp_o,
  output      logic               fast_trig_o,
  output      logic               fast_event_o,
  output      logic               reset_det_o,
  output      logic               adc_oor_o,
  output      logic        [15:0] energy_o,
  output      logic               energy_valid_o
);
  initial begin
    ramp_o = 16'sh0000;
    fast_trig_o = 1'b0;
    fast_event_o = 1'b0;
    reset_det_o = 1'b0;
    adc_oor_o = 1'b0;
    energy_o = 16'h0000;
    energy_valid_o = 1'b0;
  end

  // The preamplifier discharges its ramp as soon as the request arrives.
  always @(posedge clk_i) begin
    if (dyn_reset_i) begin
      ramp_o <= -16'sh4000;
    end
  end

  // Energy is only held while valid; afterwards the bus shows junk, not the last value.
  task automatic send_energy(input logic [15:0] e);
    @(posedge clk_i);
    energy_o <= e;
    energy_valid_o <= 1'b1;
    @(posedge clk_i);
    energy_valid_o <= 1'b0;
    energy_o <= ~e;
  endtask

  task automatic pulse_fast();
    @(posedge clk_i);
    fast_event_o <= 1'b1;
    @(posedge clk_i);
    fast_event_o <= 1'b0;
  endtask

  task automatic hold_level(input int sel, input int n);
    @(posedge clk_i);
    if (sel == 0) fast_trig_o <= 1'b1;
    if (sel == 1) reset_det_o <= 1'b1;
    if (sel == 2) adc_oor_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    fast_trig_o <= 1'b0;
    reset_det_o <= 1'b0;
    adc_oor_o <= 1'b0;
  endtask
endmodule

//--- tb/pbhs_top_tb.sv
`timescale 1ns/1ps
module pbhs_top_tb
  import pbhs_pkg::*;
;
  typedef struct {logic [31:0] v; bit chk; string nm;} pbhs_exp_type;
  logic               clk_i, nrst_i, ce_i, wr_i, rd_i, rd_seen, dr_prev;
  logic        [7:0]  addr_i;
  logic        [31:0] wdata_i, rdata_o, cyc, hi_n, r, c;
  logic signed [15:0] ramp_i;
  logic               fast_trig_i, fast_event_i, reset_det_i, adc_oor_i, energy_valid_i;
  logic        [15:0] energy_i;
  logic               dyn_reset_o;
  int                 n_errors, tests_run, seed_v, g, off, e, i;
  int                 exp_b[int];
  pbhs_exp_type       exp_q[$];
  logic        [31:0] rise_q[$];

  pbhs_top pbhs_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ramp_i(ramp_i),
    .fast_trig_i(fast_trig_i), .fast_event_i(fast_event_i), .reset_det_i(reset_det_i),
    .adc_oor_i(adc_oor_i), .energy_i(energy_i), .energy_valid_i(energy_valid_i),
    .dyn_reset_o(dyn_reset_o));
  pbhs_partner pbhs_partner_inst (.clk_i(clk_i), .dyn_reset_i(dyn_reset_o), .ramp_o(ramp_i),
    .fast_trig_o(fast_trig_i), .fast_event_o(fast_event_i), .reset_det_o(reset_det_i),
    .adc_oor_o(adc_oor_i), .energy_o(energy_i), .energy_valid_o(energy_valid_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    pbhs_exp_type n;
    n.v = ex;
    n.chk = 1'b1;
    n.nm = $sformatf("reg %h", a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(n);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic rd_val(input logic [7:0] a, output logic [31:0] v);
    rd(a, 32'h0000_0000);
    exp_q[$].chk = 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask

  function automatic int bin_of(input int en, input int gn, input int of);
    int b;
    b = ((en * gn) >>> 8) + of;
    if (b < 0) b = 0;
    if (b > 8191) b = 8191;
    return b;
  endfunction

  always @(posedge clk_i) begin
    cyc <= cyc + 32'h0000_0001;
    rd_seen <= rd_i;
  end

  // Read data stand only in the cycle after the strobe, so that is where they are taken.
  always @(negedge clk_i) begin
    pbhs_exp_type n;
    if (rd_seen === 1'b1) begin
      n = exp_q.pop_front();
      if (n.chk) check(n.nm, n.v, rdata_o);
    end
    if (dyn_reset_o === 1'b1) hi_n = hi_n + 32'h1;
    if (dyn_reset_o === 1'b1 && !dr_prev) begin
      if (rise_q.size() == 0) check("reset rise", 32'hFFFF_FFFF, cyc);
      else check("reset rise", rise_q.pop_front(), cyc);
    end
    if (dyn_reset_o !== 1'b1 && dr_prev) begin
      check("reset width", RST_PULSE_CYC, hi_n);
      hi_n = 32'h0;
    end
    dr_prev = (dyn_reset_o === 1'b1);
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

  initial begin
    {nrst_i, wr_i, rd_i, addr_i, wdata_i, cyc, hi_n, dr_prev} = '0;
    ce_i = 1'b1;
    n_errors = 0;
    tests_run = 0;
    seed_v = $urandom(70);
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(A_THR, {16'h0000, THR_RST});
    rd(A_DLY, {16'h0000, DLY_RST});
    rd(A_GAIN, {16'h0000, GAIN_RST});
    rd(A_HCFG, 32'h0003_2000);
    rd(8'h3C, 32'h0000_0000);
    $display("test reset values done");
    wr(A_THR, 32'h0000_1000);
    wr(A_DLY, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_0004);
    pbhs_partner_inst.ramp_o <= 16'sh0F00;
    repeat (20) @(posedge clk_i);
    @(posedge clk_i);
    rise_q.push_back(cyc + 32'd6);
    pbhs_partner_inst.ramp_o <= 16'sh2000;
    repeat (20) @(posedge clk_i);
    @(posedge clk_i);
    pbhs_partner_inst.ramp_o <= 16'sh2000;
    wr(A_CTRL, 32'h0000_0000);
    repeat (20) @(posedge clk_i);
    pbhs_partner_inst.ramp_o <= 16'sh0000;
    $display("test dynamic reset done");
    g = 512;
    off = 5;
    wr(A_GAIN, 32'h0000_0200);
    wr(A_OFF, 32'h0000_0005);
    wr(A_HCFG, 32'h0001_2000);
    wr(A_CTRL, 32'h0000_0001);
    for (i = 0; i < 340; i++) begin
      e = (i < 40) ? $urandom_range(0, 4095) : (i < 297) ? 100 : (i == 297) ? 65535 : 10;
      if (i == 298) begin
        off = -256;
        wr(A_OFF, 32'h0000_FF00);
      end
      if (i == 299) wr(A_OFF, 32'h0000_FE00);
      if (i == 299) e = 130;
      if (i < 300) begin
        exp_b[bin_of(e, g, off)]++;
        pbhs_partner_inst.send_energy(e[15:0]);
      end
    end
    repeat (4) @(posedge clk_i);
    foreach (exp_b[k]) begin
      wr(A_IDX, k);
      rd(A_BIN, exp_b[k] & 32'hFF);
    end
    $display("test histogram done");
    pbhs_partner_inst.hold_level(0, 3);
    pbhs_partner_inst.hold_level(1, 4);
    pbhs_partner_inst.hold_level(2, 5);
    repeat (7) pbhs_partner_inst.pulse_fast();
    wr(A_CTRL, 32'h0000_0008);
    rd_val(A_REAL, r);
    rd(A_LIVE, r - 32'd12);
    rd(A_INCNT, 32'd7);
    rd(A_OUTCN, 32'd300);
    for (i = 0; i < 20; i++) begin
      rd_val(A_CTRL, c);
      if (c[C_BUSY] === 1'b0) break;
      repeat (10) @(posedge clk_i);
    end
    check("busy end", 32'h0000_0010, c);
    rd(A_ICR, 32'((64'd7 * CLK_HZ) / (r - 32'd12)));
    rd(A_OCR, 32'((64'd300 * CLK_HZ) / r));
    $display("test statistics done");
    wr(A_HCFG, 32'h0000_0064);
    rd(A_HCFG, 32'h0001_0200);
    wr(A_IDX, 32'h0000_1FFF);
    rd(A_BIN, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0008);
    rd(A_INCNT, 32'h0000_0000);
    wr(A_HCFG, 32'h0001_2000);
    wr(A_IDX, 32'h0000_00CD);
    rd(A_BIN, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    $display("test hist config done");
    finish_test();
  end
endmodule
